// [bench/data_bus_tenure_control_tb.sv]
`default_nettype none
module data_bus_tenure_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        rst_i;
  logic        cyc, stb, we, gen, wfs, berr, aretry, bi, wr, grant, busy, ack, oe_n, lanes_oe_n;
  logic        mc, cs, burst_indicator, bk, drt, dr_en;
  logic [7:0]  adr, par;
  logic [31:0] dat, q, ta, taddr, wdo, hi, lo;
  int          n_mismatch, cmp_count;
  logic [31:0] eadr [7] = '{32'h1234, 32'h1220, 32'h1234, 32'h1234, 32'h1220, 32'h1230,
                            32'h1234};
  logic [5:0]  code [7] = '{6'h00, 6'h06, 6'h02, 6'h07, 6'h0f, 6'h16, 6'h20};
  logic [6:0]  ebi      = 7'b1110010;

  data_bus_tenure_control i_data_bus_tenure_control (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(wdo), .wb_ack_o(ack), .data_grant_in_i(grant), .write_first_select_i(wfs),
    .data_busy_line_i(busy), .data_retry_i(drt), .address_retry_i(aretry),
    .beat_acknowledge_i(bk), .bus_error_ack_i(berr), .data_high_lanes_i(hi),
    .data_low_lanes_i(lo), .data_parity_lanes_i(par), .data_busy_line_o(),
    .data_busy_line_oe_n_o(oe_n), .burst_indicator_o(burst_indicator), .tenure_addr_o(taddr),
    .data_high_lanes_o(), .data_low_lanes_o(), .data_parity_lanes_o(),
    .data_lanes_oe_n_o(lanes_oe_n), .machine_check_o(mc), .checkstop_o(cs));
  dtc_mem_model i_dtc_mem_model (.clk_i, .rst_i, .grant_en_i(gen), .busy_oe_n_i(oe_n),
    .grant_o(grant), .busy_o(busy), .ack_o(bk), .hi_o(hi), .lo_o(lo), .par_o(par));

  // ------------------------------------------
  // Tasks
  // ------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    n_mismatch++;
    $display("mismatch at %0t: timeout", $time);
    finish_test;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack && n < 20);
    q = wdo;
    {cyc, stb} <= 2'b00;
    if (n >= 20) tmo;
  endtask
  task automatic push(input logic [31:0] a, input logic [5:0] c);
    wb(1'b1, dtc_pkg::QUEUE_OFS, a);
    wb(1'b1, dtc_pkg::PUSH_OFS, {26'h0, c});
  endtask
  // One tenure; error or address retry raised once busy is seen
  task automatic run(input logic wf, input logic er, input logic ar);
    int n;
    int k;
    @(posedge clk_i);
    {wfs, gen} <= {wf, 1'b1};
    n = 0;
    k = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (oe_n && n < 60);
    if (n >= 60) tmo;
    bi = burst_indicator;
    ta = taddr;
    wr = !lanes_oe_n;
    {gen, berr, aretry} <= {1'b0, er, ar};
    do begin
      @(posedge clk_i);
      wr |= !lanes_oe_n;
      // Data retry follows the first read acknowledge, two cycles long
      if (dr_en && (bk || k != 0) && k < 3) begin
        k++;
        drt <= (k < 3);
      end
      n++;
    end while (!oe_n && n < 160);
    {wfs, berr, aretry} <= 3'b000;
    if (n >= 160) tmo;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, cyc, stb, we, gen, wfs, berr, aretry} = 8'h80;
    {drt, dr_en} = 2'b00;
    adr = 8'h00;
    dat = 32'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, dtc_pkg::CTRL_OFS, 32'h0);
    chk(q, dtc_pkg::CTRL_RST);
    wb(1'b0, dtc_pkg::EAR_OFS, 32'h0);
    chk(q, dtc_pkg::EAR_RST);
    wb(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, dtc_pkg::EAR_OFS, 32'h1000_0000);
    for (int i = 0; i < 7; i++) begin
      push(32'h0000_1234, code[i]);
      run(1'b0, 1'b0, 1'b0);
      chk({31'h0, bi}, {31'h0, ebi[i]});
      chk(ta, eadr[i]);
      wb(1'b0, dtc_pkg::STATUS_OFS, 32'h0);
      chk(q & 32'h1, 32'h1);
      wb(1'b1, dtc_pkg::STATUS_OFS, 32'h1f);
    end
    wb(1'b0, dtc_pkg::DLO_OFS, 32'h0);
    chk(q, 32'ha5a5_0002);
    wb(1'b0, dtc_pkg::DHI_OFS, 32'h0);
    chk(q, 32'h5a5a_0001);
    wb(1'b0, dtc_pkg::PAR_OFS, 32'h0);
    chk(q, 32'h0000_003c);
    $display("test kinds done");
    push(32'h100, 6'h00);
    push(32'h200, 6'h0f);
    push(32'h300, 6'h00);
    wb(1'b0, dtc_pkg::QUEUE_OFS, 32'h0);
    chk(q & 32'h3, 32'h2);
    run(1'b1, 1'b0, 1'b0);
    chk(ta, 32'h200);
    chk({31'h0, wr}, 32'h1);
    run(1'b0, 1'b0, 1'b0);
    chk(ta, 32'h100);
    push(32'h40, 6'h01);
    push(32'h80, 6'h00);
    run(1'b0, 1'b0, 1'b0);
    chk(ta, 32'h40);
    run(1'b0, 1'b0, 1'b0);
    chk(ta, 32'h80);
    wb(1'b0, dtc_pkg::QUEUE_OFS, 32'h0);
    chk(q & 32'h3, 32'h0);
    $display("test order done");
    push(32'h400, 6'h00);
    run(1'b1, 1'b1, 1'b0);
    chk(ta, 32'h400);
    wb(1'b0, dtc_pkg::STATUS_OFS, 32'h0);
    chk(q & 32'h1c, 32'h14);
    chk({31'h0, mc}, 32'h1);
    wb(1'b1, dtc_pkg::STATUS_OFS, 32'h1f);
    wb(1'b1, dtc_pkg::CTRL_OFS, 32'h0);
    push(32'h500, 6'h00);
    run(1'b0, 1'b1, 1'b0);
    wb(1'b0, dtc_pkg::STATUS_OFS, 32'h0);
    chk(q & 32'h1c, 32'h0c);
    chk({31'h0, cs}, 32'h1);
    wb(1'b1, dtc_pkg::STATUS_OFS, 32'h1f);
    push(32'h600, 6'h00);
    run(1'b0, 1'b0, 1'b1);
    wb(1'b0, dtc_pkg::STATUS_OFS, 32'h0);
    chk(q & 32'h2, 32'h2);
    $display("test errors done");
    wb(1'b1, dtc_pkg::STATUS_OFS, 32'h1f);
    push(32'h700, 6'h00);
    dr_en = 1'b1;
    run(1'b0, 1'b0, 1'b0);
    dr_en = 1'b0;
    wb(1'b0, dtc_pkg::STATUS_OFS, 32'h0);
    chk(q & 32'h3, 32'h1);
    wb(1'b0, dtc_pkg::DLO_OFS, 32'h0);
    chk(q, 32'ha5a5_0002);
    $display("test retry done");
    finish_test;
  end
endmodule
`default_nettype wire

// [bench/dtc_mem_model.sv]
`default_nettype none
module dtc_mem_model (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         grant_en_i,
  input wire logic         busy_oe_n_i,
  output logic             grant_o,
  output logic             busy_o,
  output logic             ack_o,
  output logic      [31:0] hi_o,
  output logic      [31:0] lo_o,
  output logic      [7:0]  par_o
);
  // ------------------------------------------
  // Arbiter and slave
  // ------------------------------------------
  logic [3:0] cnt_r;
  logic       beat;
  // Line is wired, so the device reads back its own busy
  assign busy_o = !busy_oe_n_i;
  assign beat   = !busy_oe_n_i && cnt_r >= 4'h3;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {grant_o, ack_o, cnt_r, hi_o, lo_o, par_o} <= '0;
    end else begin
      grant_o <= grant_en_i && busy_oe_n_i;
      cnt_r   <= (busy_oe_n_i || cnt_r == 4'h6) ? 4'h0 : cnt_r + 4'h1;
      ack_o   <= beat;
      // Released lanes toggle so stale data never looks valid
      hi_o    <= beat ? 32'h5a5a_0001 : ~hi_o;
      lo_o    <= beat ? 32'ha5a5_0002 : ~lo_o;
      par_o   <= beat ? 8'h3c : ~par_o;
    end
  end
endmodule
`default_nettype wire

// [bench/dtc_props.sv]
`default_nettype none
module dtc_props (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic data_grant_in_i,
  input wire logic data_busy_line_i,
  input wire logic data_retry_i,
  input wire logic address_retry_i,
  input wire logic bus_error_ack_i,
  input wire logic data_busy_line_o,
  input wire logic data_busy_line_oe_n_o,
  input wire logic data_lanes_oe_n_o,
  input wire logic machine_check_o,
  input wire logic checkstop_o
);
  // ------------------------------------------
  // Age of the last raw qualified grant
  // ------------------------------------------
  logic [3:0] q_age_r;
  logic [3:0] q_age_nxt;
  always_comb begin
    q_age_nxt = q_age_r;
    if (data_grant_in_i && !data_busy_line_i && !data_retry_i && !address_retry_i) begin
      q_age_nxt = 4'h0;
    end else if (q_age_r != 4'hf) begin
      q_age_nxt = q_age_r + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    q_age_r <= rst_i ? 4'hf : q_age_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_berr;
    (!data_busy_line_oe_n_o && bus_error_ack_i) [*4];
  endsequence
  sequence s_aretry;
    (!data_busy_line_oe_n_o && address_retry_i) [*4];
  endsequence
  property p_take;
    $fell(data_busy_line_oe_n_o) |-> q_age_r < 4'h8;
  endproperty
  a_take: assert property (p_take) else $error("busy without a grant");
  property p_gap;
    $rose(data_busy_line_oe_n_o) |-> data_busy_line_oe_n_o [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("busy gap too short");
  property p_lanes;
    !data_lanes_oe_n_o |-> !data_busy_line_oe_n_o && !data_busy_line_o;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lanes driven outside tenure");
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_berr_end;
    s_berr |-> ##[1:3] data_busy_line_oe_n_o;
  endproperty
  a_berr_end: assert property (p_berr_end) else $error("error did not end tenure");
  property p_berr_evt;
    s_berr |-> ##[1:8] (machine_check_o || checkstop_o);
  endproperty
  a_berr_evt: assert property (p_berr_evt) else $error("error not flagged");
  property p_aretry;
    s_aretry |-> ##[1:3] data_busy_line_oe_n_o;
  endproperty
  a_aretry: assert property (p_aretry) else $error("retry did not end tenure");
endmodule
bind data_bus_tenure_control dtc_props i_dtc_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .data_grant_in_i, .data_busy_line_i, .data_retry_i, .address_retry_i,
  .bus_error_ack_i, .data_busy_line_o, .data_busy_line_oe_n_o, .data_lanes_oe_n_o,
  .machine_check_o, .checkstop_o);
`default_nettype wire

// [pkg/dtc_pkg.sv]
`default_nettype none
package dtc_pkg;
  // ---------------------------------------------------------------
  // Register map (word offsets as byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] QUEUE_OFS  = 8'h08;
  localparam logic [7:0] DLO_OFS    = 8'h0c;
  localparam logic [7:0] DHI_OFS    = 8'h10;
  localparam logic [7:0] PAR_OFS    = 8'h14;
  localparam logic [7:0] EAR_OFS    = 8'h18;
  localparam logic [7:0] PUSH_OFS   = 8'h1c;

  localparam int CTRL_ME_BIT     = 0;
  localparam int CTRL_NORETRY    = 1;
  localparam int EAR_BURST_BIT   = 28;

  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] EAR_RST  = 32'h0000_0000;

  localparam logic [2:0] BURST_BEATS = 3'h4;
  localparam int         QUEUE_DEPTH = 2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic        burst_req;
    logic        cacheable;
    logic        write_back;
    logic        line_fill;
    logic        ext_ctrl;
    logic [31:0] addr;
  } tenure_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DATA  = 2'b01,
    ST_HOLD  = 2'b11,
    ST_GAP   = 2'b10
  } dstate_t;

  typedef struct packed {
    logic        machine_check;
    logic        checkstop;
    logic        bus_error;
    logic        retried;
    logic        done;
  } evt_t;
endpackage
`default_nettype wire

// [verilog/data_bus_tenure_control.sv]
`default_nettype none
// Behaviour
// - Grant counts only while busy, data retry, own address retry negated.
// - Busy asserts cycle after qualified grant, unless own address retry then.
// - Any address retry, own or newer, ends the active data tenure.
// - Own busy always observed; one idle cycle after tenure before new grant.
// - Up to two pending tenures, run in push order by default.
// - Write-first select at qualified grant runs pending write before read.
// - Pending tenure always taken on grant; no write means next read.
// - 64-bit data path in two 32-bit halves plus eight parity lanes.
// - Single beat moves 1-8 bytes; burst four beats, eight-word aligned.
// - Bursts only cacheable, and stores only when also write-back.
// - Burst indicator shows burst tenure, or external register bit 28.
// - Line-fill bursts start at critical double word, else line aligned.
// - Data retry extends read beat; ignored during writes.
// - Data retry after last beat: busy drops, beat still awaits acknowledge.
// - Final termination drops busy for at least two cycles.
// - Bus error ends tenure at once; machine check or checkstop by enable.
// - Own address retry ends active data tenure immediately.
module data_bus_tenure_control (
  // Clock and reset
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  // Wishbone slave
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output logic       [31:0] wb_dat_o,
  output logic              wb_ack_o,
  // Bus pins, sampled
  input  wire  logic        data_grant_in_i,
  input  wire  logic        write_first_select_i,
  input  wire  logic        data_busy_line_i,
  input  wire  logic        data_retry_i,
  input  wire  logic        address_retry_i,
  input  wire  logic        beat_acknowledge_i,
  input  wire  logic        bus_error_ack_i,
  input  wire  logic [31:0] data_high_lanes_i,
  input  wire  logic [31:0] data_low_lanes_i,
  input  wire  logic [7:0]  data_parity_lanes_i,
  // Bus pins, driven
  output logic              data_busy_line_o,
  output logic              data_busy_line_oe_n_o,
  output logic              burst_indicator_o,
  output logic       [31:0] tenure_addr_o,
  output logic       [31:0] data_high_lanes_o,
  output logic       [31:0] data_low_lanes_o,
  output logic       [7:0]  data_parity_lanes_o,
  output logic              data_lanes_oe_n_o,
  // Events
  output logic              machine_check_o,
  output logic              checkstop_o
);
  // ---------------------------------------------------------------
  // Input synchronisers: change counts when stages two and three agree
  // ---------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw, s1_r, s2_r, s3_r, flt_r, flt_nxt;
  assign raw = {data_grant_in_i, write_first_select_i, data_busy_line_i,
                data_retry_i, address_retry_i, beat_acknowledge_i, bus_error_ack_i};
  always_comb begin
    flt_nxt = flt_r;
    for (int i = 0; i < NSYNC; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        flt_nxt[i] = s3_r[i];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      flt_r <= '0;
    end else begin
      s1_r  <= raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
    end
  end
  logic grant, wfirst, busy_ext, dretry, aretry, ack, berr;
  assign {grant, wfirst, busy_ext, dretry, aretry, ack, berr} = flt_r;

  // Lanes are too wide to filter; delaying them as far as the
  // acknowledge keeps each beat's data paired with its acknowledge
  localparam int LANE_W = 72;
  logic [LANE_W-1:0] lane_d_r [4];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_d_r[0] <= '0;
      lane_d_r[1] <= '0;
      lane_d_r[2] <= '0;
      lane_d_r[3] <= '0;
    end else begin
      lane_d_r[0] <= {data_high_lanes_i, data_low_lanes_i, data_parity_lanes_i};
      lane_d_r[1] <= lane_d_r[0];
      lane_d_r[2] <= lane_d_r[1];
      lane_d_r[3] <= lane_d_r[2];
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_burst(input dtc_pkg::tenure_t t);
    is_burst = t.burst_req && t.cacheable && (!t.write || t.write_back);
  endfunction
  function automatic logic [31:0] start_addr(input dtc_pkg::tenure_t t);
    if (is_burst(t) && t.line_fill) begin
      start_addr = {t.addr[31:3], 3'h0};
    end else if (is_burst(t)) begin
      start_addr = {t.addr[31:5], 5'h00};
    end else begin
      start_addr = t.addr;
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dtc_pkg::tenure_t q_r [dtc_pkg::QUEUE_DEPTH];
  dtc_pkg::tenure_t q_nxt [dtc_pkg::QUEUE_DEPTH];
  dtc_pkg::tenure_t cur_r, cur_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  dtc_pkg::dstate_t st_r, st_nxt;
  logic [2:0]  beats_r, beats_nxt;
  logic        busy_r, busy_nxt;
  logic        rd_ack_r, rd_ack_nxt;
  logic [31:0] ctrl_r, ctrl_nxt, ear_r, ear_nxt;
  logic [31:0] dlo_r, dlo_nxt, dhi_r, dhi_nxt;
  logic [7:0]  par_r, par_nxt;
  dtc_pkg::evt_t evt_r, evt_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [31:0] pend_addr_r, pend_addr_nxt;

  logic wb_req, wb_wr, push, qgrant, pick_one, is_last;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wb_wr  = wb_req && wb_we_i && (wb_sel_i == 4'hf);
  assign push   = wb_wr && (wb_adr_i == dtc_pkg::PUSH_OFS) && (cnt_r != 2'h2);
  // Own busy is always seen even when the system ignores the line
  assign qgrant = grant && !busy_ext && !busy_r && !dretry && !aretry
                  && (st_r == dtc_pkg::ST_IDLE) && (cnt_r != 2'h0);
  // Write-first: entry one is the write, entry zero a read
  assign pick_one = wfirst && (cnt_r == 2'h2) && !q_r[0].write && q_r[1].write;
  assign is_last = is_burst(cur_r) ? (beats_r == dtc_pkg::BURST_BEATS - 3'h1) : 1'b1;

  always_comb begin
    q_nxt[0]      = q_r[0];
    q_nxt[1]      = q_r[1];
    cnt_nxt       = cnt_r;
    cur_nxt       = cur_r;
    st_nxt        = st_r;
    beats_nxt     = beats_r;
    busy_nxt      = busy_r;
    rd_ack_nxt    = 1'b0;
    dlo_nxt       = dlo_r;
    dhi_nxt       = dhi_r;
    par_nxt       = par_r;
    evt_nxt       = evt_r;
    ctrl_nxt      = ctrl_r;
    ear_nxt       = ear_r;
    pend_addr_nxt = pend_addr_r;
    ack_nxt       = wb_req;
    rdat_nxt      = 32'h0;
    // Register writes
    if (wb_wr) begin
      case (wb_adr_i)
        dtc_pkg::CTRL_OFS:   ctrl_nxt = wb_dat_i;
        dtc_pkg::EAR_OFS:    ear_nxt = wb_dat_i;
        dtc_pkg::DLO_OFS:    dlo_nxt = wb_dat_i;
        dtc_pkg::DHI_OFS:    dhi_nxt = wb_dat_i;
        dtc_pkg::PAR_OFS:    par_nxt = wb_dat_i[7:0];
        dtc_pkg::QUEUE_OFS:  pend_addr_nxt = wb_dat_i;
        dtc_pkg::STATUS_OFS: evt_nxt = evt_r & ~dtc_pkg::evt_t'(wb_dat_i[4:0]);
        default: ;
      endcase
    end
    // Tenure sequencing
    case (st_r)
      dtc_pkg::ST_IDLE: begin
        if (qgrant) begin
          cur_nxt   = pick_one ? q_r[1] : q_r[0];
          q_nxt[0]  = pick_one ? q_r[0] : q_r[1];
          cnt_nxt   = cnt_r - 2'h1;
          beats_nxt = 3'h0;
          busy_nxt  = 1'b1;
          st_nxt    = dtc_pkg::ST_DATA;
        end
      end
      dtc_pkg::ST_DATA, dtc_pkg::ST_HOLD: begin
        if (aretry) begin
          busy_nxt = 1'b0;
          evt_nxt.retried = 1'b1;
          st_nxt = dtc_pkg::ST_GAP;
        end else if (berr) begin
          busy_nxt = 1'b0;
          evt_nxt.bus_error = 1'b1;
          if (ctrl_r[dtc_pkg::CTRL_ME_BIT]) begin
            evt_nxt.machine_check = 1'b1;
          end else begin
            evt_nxt.checkstop = 1'b1;
          end
          st_nxt = dtc_pkg::ST_GAP;
        end else if (dretry && rd_ack_r && !cur_r.write
                     && !ctrl_r[dtc_pkg::CTRL_NORETRY]) begin
          // Undo last beat; it stays open for another acknowledge
          beats_nxt = beats_r - 3'h1;
          busy_nxt  = 1'b0;
          st_nxt    = dtc_pkg::ST_HOLD;
        end else if (ack) begin
          if (!cur_r.write) begin
            dhi_nxt = lane_d_r[3][71:40];
            dlo_nxt = lane_d_r[3][39:8];
            par_nxt = lane_d_r[3][7:0];
            rd_ack_nxt = 1'b1;
          end
          beats_nxt = beats_r + 3'h1;
          if (is_last) begin
            busy_nxt = 1'b0;
            evt_nxt.done = 1'b1;
            // A read may still see a retry next cycle
            st_nxt = (!cur_r.write && !ctrl_r[dtc_pkg::CTRL_NORETRY])
                     ? dtc_pkg::ST_HOLD : dtc_pkg::ST_GAP;
          end
        end else if (st_r == dtc_pkg::ST_HOLD && !busy_r) begin
          st_nxt = dtc_pkg::ST_GAP;
        end
      end
      dtc_pkg::ST_GAP: st_nxt = dtc_pkg::ST_IDLE;
      default: st_nxt = dtc_pkg::ST_IDLE;
    endcase
    if (push) begin
      q_nxt[cnt_nxt[0]] = '{write: wb_dat_i[0], burst_req: wb_dat_i[1],
                           cacheable: wb_dat_i[2], write_back: wb_dat_i[3],
                           line_fill: wb_dat_i[4], ext_ctrl: wb_dat_i[5],
                           addr: pend_addr_r};
      cnt_nxt = cnt_nxt + 2'h1;
    end
    // Register reads
    case (wb_adr_i)
      dtc_pkg::CTRL_OFS:   rdat_nxt = ctrl_r;
      dtc_pkg::STATUS_OFS: rdat_nxt = {24'h0, st_r, busy_r, evt_r};
      dtc_pkg::QUEUE_OFS:  rdat_nxt = {27'h0, beats_r, cnt_r};
      dtc_pkg::DLO_OFS:    rdat_nxt = dlo_r;
      dtc_pkg::DHI_OFS:    rdat_nxt = dhi_r;
      dtc_pkg::PAR_OFS:    rdat_nxt = {24'h0, par_r};
      dtc_pkg::EAR_OFS:    rdat_nxt = ear_r;
      default:             rdat_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r[0]      <= '0;
      q_r[1]      <= '0;
      cur_r       <= '0;
      cnt_r       <= 2'h0;
      st_r        <= dtc_pkg::ST_IDLE;
      beats_r     <= 3'h0;
      busy_r      <= 1'b0;
      rd_ack_r    <= 1'b0;
      ctrl_r      <= dtc_pkg::CTRL_RST;
      ear_r       <= dtc_pkg::EAR_RST;
      dlo_r       <= 32'h0;
      dhi_r       <= 32'h0;
      par_r       <= 8'h0;
      evt_r       <= '0;
      ack_r       <= 1'b0;
      rdat_r      <= 32'h0;
      pend_addr_r <= 32'h0;
    end else begin
      q_r[0]      <= q_nxt[0];
      q_r[1]      <= q_nxt[1];
      cur_r       <= cur_nxt;
      cnt_r       <= cnt_nxt;
      st_r        <= st_nxt;
      beats_r     <= beats_nxt;
      busy_r      <= busy_nxt;
      rd_ack_r    <= rd_ack_nxt;
      ctrl_r      <= ctrl_nxt;
      ear_r       <= ear_nxt;
      dlo_r       <= dlo_nxt;
      dhi_r       <= dhi_nxt;
      par_r       <= par_nxt;
      evt_r       <= evt_nxt;
      ack_r       <= ack_nxt;
      rdat_r      <= rdat_nxt;
      pend_addr_r <= pend_addr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_ack_o              = ack_r;
  assign wb_dat_o              = rdat_r;
  assign data_busy_line_o      = 1'b0;
  assign data_busy_line_oe_n_o = !busy_r;
  assign burst_indicator_o     = cur_r.ext_ctrl ? ear_r[dtc_pkg::EAR_BURST_BIT]
                                                : is_burst(cur_r);
  assign tenure_addr_o         = start_addr(cur_r);
  assign data_high_lanes_o     = dhi_r;
  assign data_low_lanes_o      = dlo_r;
  assign data_parity_lanes_o   = par_r;
  // Drive lanes only while busy on a write
  assign data_lanes_oe_n_o     = !(busy_r && cur_r.write && st_r == dtc_pkg::ST_DATA);
  assign machine_check_o       = evt_r.machine_check;
  assign checkstop_o           = evt_r.checkstop;
endmodule
`default_nettype wire
